// ==== core/dec_exec_pkg.sv ====
package dec_exec_pkg;
  // ---------------------------------------------------------------
  // opcode layout
  // ---------------------------------------------------------------
  localparam int INSTR_W = 16;
  localparam int DATA_W = 8;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 9;
  localparam int DEST_BIT = 8;
  localparam logic [6:0] OPC_DECREMENT_FILE = 7'h03;      // 0000 011
  localparam logic [6:0] OPC_DECREMENT_SKIP_ZERO = 7'h0B; // 0001 011
  localparam logic DEST_WORKING = 1'b0;
  // ---------------------------------------------------------------
  // status flag positions within the flag vector
  // ---------------------------------------------------------------
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DIGIT_CARRY = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_W = 4;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_FORCED_NOP = 2'b10
  } exec_state_t;
endpackage

// ==== core/dec_alu.sv ====
`timescale 1ns/1ps
module dec_alu
  import dec_exec_pkg::*;
(
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic [3:0] flags
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  // decrement as operand + 0xFF, so carry means no borrow
  always_comb begin
    sum = {1'b0, operand} + 9'h0FF;
    low_sum = {1'b0, operand[3:0]} + 5'h0F;
    result = sum[7:0];
    flags = FLAGS_RESET;
    flags[FLAG_CARRY] = sum[8];
    flags[FLAG_DIGIT_CARRY] = low_sum[4];
    flags[FLAG_ZERO] = (sum[7:0] == 8'h00);
    // signed overflow only when 0x80 wraps to 0x7F
    flags[FLAG_OVERFLOW] = operand[7] & ~sum[7];
  end
endmodule

// ==== core/decrement_instruction_exec.sv ====
`timescale 1ns/1ps
module decrement_instruction_exec
  import dec_exec_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [7:0] file_rdata,
  input wire logic [3:0] flags_in,
  output logic [7:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic working_we,
  output logic [7:0] working_register,
  output logic flags_we,
  output logic [3:0] flags_out,
  output logic discard_fetch,
  output logic nop_cycle,
  output logic busy
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;
  // async assert, synchronous release through two stages
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  // everything below resets from this copy, never from the pin itself
  assign rst_n = rst_sync2_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic is_opc(input logic [15:0] word, input logic [6:0] opc);
    is_opc = (word[OPC_HI:OPC_LO] == opc);
  endfunction

  // file address field of a decrement word
  function automatic logic [7:0] file_field(input logic [15:0] word);
    file_field = word[7:0];
  endfunction

  // a decremented value of zero is what triggers the skip
  function automatic logic is_zero(input logic [7:0] value);
    is_zero = (value == 8'h00);
  endfunction

  exec_state_t state_reg;
  exec_state_t state_next;
  logic is_dec;
  logic is_dsz;
  logic dest_file;
  logic decode_hit;
  logic [7:0] alu_result;
  logic [3:0] alu_flags;

  // fetched word in a forced slot is never decoded
  always_comb begin
    is_dec = instr_valid && (state_reg == ST_RUN) && is_opc(instr, OPC_DECREMENT_FILE);
    is_dsz = instr_valid && (state_reg == ST_RUN) && is_opc(instr, OPC_DECREMENT_SKIP_ZERO);
    dest_file = (instr[DEST_BIT] != DEST_WORKING);
    decode_hit = is_dec || is_dsz;
  end

  dec_alu u_alu (
    .operand(file_rdata),
    .result(alu_result),
    .flags(alu_flags)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // slot control signals
  logic result_zero;
  logic skip_taken;
  logic in_forced_slot;

  // zero test on the decremented value arms the forced slot
  always_comb begin
    result_zero = is_zero(alu_result);
    skip_taken = is_dsz && result_zero;
    in_forced_slot = (state_reg == ST_FORCED_NOP);
  end

  // next state: one forced slot, then back to normal issue
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (skip_taken) begin
          state_next = ST_FORCED_NOP;
        end
      end
      ST_FORCED_NOP: begin
        // prefetched word dropped, the slot runs as a no-operation
        state_next = ST_RUN;
      end
      default: begin
        // an illegal code falls back to normal issue instead of hanging
        state_next = ST_RUN;
      end
    endcase
  end

  // sequencer register only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // writeback to file register or working register
  // ---------------------------------------------------------------
  // next values
  logic file_we_next;
  logic [7:0] file_wdata_next;
  logic [7:0] file_addr_next;
  logic working_we_next;
  logic [7:0] working_next;
  // registered copies
  logic file_we_reg;
  logic [7:0] file_wdata_reg;
  logic [7:0] file_addr_reg;
  logic working_we_reg;
  logic [7:0] working_reg;

  // enables are one-cycle pulses; data holds until the next decrement
  always_comb begin
    file_we_next = 1'b0;
    file_wdata_next = file_wdata_reg;
    file_addr_next = file_addr_reg;
    working_we_next = 1'b0;
    working_next = working_reg;
    if (decode_hit) begin
      file_addr_next = file_field(instr);
      if (dest_file) begin
        file_we_next = 1'b1;
        file_wdata_next = alu_result;
      end else begin
        working_we_next = 1'b1;
        working_next = alu_result;
      end
    end
  end

  // writeback registers only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      file_we_reg <= 1'b0;
      file_wdata_reg <= DATA_RESET;
      file_addr_reg <= DATA_RESET;
      working_we_reg <= 1'b0;
      working_reg <= DATA_RESET;
    end else begin
      file_we_reg <= file_we_next;
      file_wdata_reg <= file_wdata_next;
      file_addr_reg <= file_addr_next;
      working_we_reg <= working_we_next;
      working_reg <= working_next;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic flags_we_next;
  logic [3:0] flags_next;
  logic flags_we_reg;
  logic [3:0] flags_reg;

  // only the plain decrement writes flags; the skip form leaves them be
  always_comb begin
    flags_we_next = 1'b0;
    flags_next = flags_reg;
    if (is_dec) begin
      flags_we_next = 1'b1;
      flags_next = alu_flags;
    end
  end

  // flag registers only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_we_reg <= 1'b0;
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_we_reg <= flags_we_next;
      flags_reg <= flags_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // address follows decode combinationally so the read is in-cycle
  assign file_addr = decode_hit ? file_field(instr) : file_addr_reg;
  assign file_we = file_we_reg;
  assign file_wdata = file_wdata_reg;
  assign working_we = working_we_reg;
  assign working_register = working_reg;
  assign flags_we = flags_we_reg;
  // flags pass through unless this block wrote them on the last edge
  assign flags_out = flags_we_reg ? flags_reg : flags_in;
  // one slot signal, fanned out so fetch, issue and stall each get a copy
  assign nop_cycle = in_forced_slot;
  assign discard_fetch = in_forced_slot;
  assign busy = in_forced_slot;
endmodule

// ==== verif/dec_exec_props.sv ====
`timescale 1ns/1ps
module dec_exec_props
  import dec_exec_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  input wire logic working_we,
  input wire logic [7:0] working_register,
  input wire logic flags_we,
  input wire logic [3:0] flags_out,
  input wire logic discard_fetch,
  input wire logic nop_cycle,
  input wire logic busy
);
  // takes only; a word offered in the forced slot counts for nothing
  wire plain = instr_valid && !busy && instr[15:9] == OPC_DECREMENT_FILE;
  wire skip = instr_valid && !busy && instr[15:9] == OPC_DECREMENT_SKIP_ZERO;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_plain_to_file: assert property (plain && instr[8] |=>
    file_we && file_wdata == $past(file_rdata) - 8'h01) else $error("bad file write");
  a_plain_to_work: assert property (plain && !instr[8] |=>
    working_we && working_register == $past(file_rdata) - 8'h01) else $error("bad w write");
  a_skip_dest_route: assert property (skip |=>
    file_we == $past(instr[8]) && working_we != $past(instr[8])) else $error("bad route");
  a_skip_zero_eats: assert property (skip && file_rdata == 8'h01 |=>
    discard_fetch && nop_cycle ##1 !busy) else $error("skip slot wrong");
  a_skip_nonzero_runs: assert property (skip && file_rdata != 8'h01 |=>
    !discard_fetch) else $error("spurious skip");
  a_skip_keeps_flags: assert property (skip |=> !flags_we) else $error("flags hit");
  a_plain_zero_flag: assert property (plain |=> flags_we &&
    flags_out[FLAG_ZERO] == ($past(file_rdata) == 8'h01)) else $error("bad zero flag");
  c_plain: cover property (plain);
  c_skip_taken: cover property (skip && file_rdata == 8'h01);
  c_skip_not: cover property (skip && file_rdata != 8'h01);
endmodule
bind decrement_instruction_exec dec_exec_props i_props (.clock(clock), .reset_n(reset_n),
  .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata), .file_we(file_we),
  .file_wdata(file_wdata), .working_we(working_we), .working_register(working_register),
  .flags_we(flags_we), .flags_out(flags_out), .discard_fetch(discard_fetch),
  .nop_cycle(nop_cycle), .busy(busy));

// ==== verif/test_decrement_instruction_exec.sv ====
`timescale 1ns/1ps
module test_decrement_instruction_exec
  import dec_exec_pkg::*;
;
  logic clock = 0, reset_n = 0, instr_valid = 0;
  logic [15:0] instr = 16'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic [3:0] flags_in = 4'h0;
  logic [7:0] file_addr, file_wdata, working_register;
  logic file_we, working_we, flags_we, discard_fetch, nop_cycle, busy;
  logic [3:0] flags_out;
  logic [7:0] vals [4] = '{8'h01, 8'h00, 8'h80, 8'h10};
  int n_fail = 0, n_tests = 0;
  decrement_instruction_exec i_dut (.clock(clock), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata), .flags_in(flags_in),
    .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .working_we(working_we), .working_register(working_register), .flags_we(flags_we),
    .flags_out(flags_out), .discard_fetch(discard_fetch), .nop_cycle(nop_cycle),
    .busy(busy));
  always #5 clock = ~clock;
  // ----------------------------------------
  // shared drivers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one word for one cycle; nxt leaves a plain decrement behind for the next slot
  task automatic op(input logic [6:0] o, input logic d, input logic [7:0] r, input logic nxt);
    @(posedge clock); #1;
    instr_valid = 1;
    instr = {o, d, 8'h5A};
    file_rdata = r;
    flags_in = ~r[3:0];
    #1;
    if (o == OPC_DECREMENT_FILE || o == OPC_DECREMENT_SKIP_ZERO)
      chk("addr", file_addr, 8'h5A);
    @(posedge clock); #1;
    instr_valid = nxt;
    instr = {OPC_DECREMENT_FILE, 1'b0, 8'h33};
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_plain;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = vals[i >> 1];
      op(OPC_DECREMENT_FILE, i[0], v, 1'b0);
      chk("we", {file_we, working_we}, 8'(1 + i[0]));
      chk("data", i[0] ? file_wdata : working_register, v - 8'h01);
      chk("flags", {flags_we, flags_out},
        8'({1'b1, v == 8'h80, v == 8'h01, v[3:0] != 4'h0, v != 8'h00}));
      chk("noskip", discard_fetch, 8'h00);
    end
    op(7'h02, 1'b1, 8'h05, 1'b0);
    chk("other", {file_we, working_we, flags_we}, 8'h00);
    $display("plain decrement done");
  endtask
  // last two values give a zero result: the word offered meanwhile must vanish
  task automatic t_skip;
    logic [7:0] v;
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? 8'h02 : (i < 4) ? 8'h00 : 8'h01;
      op(OPC_DECREMENT_SKIP_ZERO, i[0], v, v == 8'h01);
      chk("route", {file_we, working_we}, 8'(1 + i[0]));
      chk("data", i[0] ? file_wdata : working_register, v - 8'h01);
      chk("flags", {flags_we, flags_out}, {4'h0, ~v[3:0]});
      chk("slot", {discard_fetch, nop_cycle, busy}, v == 8'h01 ? 8'h07 : 8'h00);
      if (v == 8'h01) begin
        @(posedge clock); #1;
        instr_valid = 0;
        chk("eaten", {file_we, working_we, flags_we, busy}, 8'h00);
      end
    end
    $display("skip decrement done");
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog: the whole run needs well under 100 cycles
  initial begin
    #5000;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clock);
    #1 reset_n = 1;
    repeat (2) @(posedge clock);
    t_plain();
    t_skip();
    end_of_test();
  end
endmodule
